// ---- hw/prc_remap.sv ----
`timescale 1ns/100ps
module prc_remap (
  input  wire logic                                 clk_in,
  input  wire logic                                 rst_n_in,
  input  wire prc_pkg::prc_map_wr_s                 map_wr_in,
  input  wire logic                                 lock_set_in,
  input  wire logic                                 key_wr_in,
  input  wire logic [7:0]                           key_data_in,
  output logic                                      locked_out,
  input  wire prc_pkg::prc_bank_wr_s                cn_en_wr_in,
  input  wire prc_pkg::prc_bank_wr_s                pu_wr_in,
  input  wire prc_pkg::prc_bank_wr_s                pd_wr_in,
  input  wire logic [prc_pkg::CD_PINS-1:0]          cd_pin_in,
  input  wire logic                                 cd_flag_clr_in,
  output logic                                      cd_irq_out,
  output logic [prc_pkg::CD_PINS-1:0]               pullup_out,
  output logic [prc_pkg::CD_PINS-1:0]               pulldown_out,
  input  wire logic [prc_pkg::REMAP_PINS-1:0]       rp_pin_in,
  input  wire logic [prc_pkg::REMAP_PINS-1:0]       rp_analog_in,
  input  wire logic [prc_pkg::BIDIR_PINS-1:0]       port_dir_in,
  input  wire logic [prc_pkg::BIDIR_PINS-1:0]       port_lat_in,
  input  wire logic [prc_pkg::BIDIR_PINS-1:0]       pmp_oe_in,
  input  wire logic [prc_pkg::BIDIR_PINS-1:0]       pmp_dat_in,
  input  wire logic [prc_pkg::BIDIR_PINS-1:0]       special_oe_in,
  input  wire logic [prc_pkg::BIDIR_PINS-1:0]       special_dat_in,
  input  wire logic [prc_pkg::OUT_FUNCS-1:0]        periph_out_in,
  input  wire logic [prc_pkg::OUT_FUNCS-1:0]        periph_oe_in,
  output logic [prc_pkg::IN_FUNCS-1:0]              periph_in_out,
  output logic [prc_pkg::BIDIR_PINS-1:0]            rp_pin_out,
  output logic [prc_pkg::BIDIR_PINS-1:0]            rp_oe_out
);
  localparam int unsigned NW = prc_pkg::CD_BANKS * prc_pkg::BANK_W;

  logic       rst_s1_reg;
  logic       rst_sync_n;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  // lock sequencer: locked from reset, two keys in a row open it
  prc_pkg::prc_lock_e lock_reg;
  prc_pkg::prc_lock_e lock_next;
  always_comb
  begin
    lock_next = lock_reg;
    unique case (lock_reg)
      prc_pkg::LK_LOCKED:
        if (key_wr_in && key_data_in == prc_pkg::UNLOCK_KEY1)
          lock_next = prc_pkg::LK_KEY1;
      // a repeated first key restarts the pair instead of failing it
      prc_pkg::LK_KEY1:
        if (key_wr_in && key_data_in == prc_pkg::UNLOCK_KEY2)
          lock_next = prc_pkg::LK_OPEN;
        else if (key_wr_in && key_data_in == prc_pkg::UNLOCK_KEY1)
          lock_next = prc_pkg::LK_KEY1;
        else
          lock_next = prc_pkg::LK_LOCKED;
      prc_pkg::LK_OPEN:
        if (lock_set_in)
          lock_next = prc_pkg::LK_LOCKED;
      default:
        lock_next = prc_pkg::LK_LOCKED;
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      lock_reg <= prc_pkg::LK_LOCKED;
    else
      lock_reg <= lock_next;
  end
  assign locked_out = (lock_reg != prc_pkg::LK_OPEN);

  // mapping fields; inputs reset to an unused pin code, outputs to null
  logic [prc_pkg::SEL_W-1:0] in_map_reg  [prc_pkg::IN_FUNCS];
  logic [prc_pkg::SEL_W-1:0] out_map_reg [prc_pkg::BIDIR_PINS];
  wire map_ok = map_wr_in.wr && !locked_out;
  // out-of-range indices match no entry, so such writes fall away silently
  wire out_wr = map_ok && map_wr_in.out_sel;
  wire in_wr  = map_ok && !map_wr_in.out_sel;
  genvar gm;
  generate
    for (gm = 0; gm < prc_pkg::IN_FUNCS; gm++)
    begin : g_in_map
      wire hit = in_wr && (map_wr_in.index == 6'(gm));
      always_ff @(posedge clk_in or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
          in_map_reg[gm] <= prc_pkg::IN_RESET;
        else if (hit)
          in_map_reg[gm] <= map_wr_in.value;
      end
    end
    for (gm = 0; gm < prc_pkg::BIDIR_PINS; gm++)
    begin : g_out_map
      wire hit = out_wr && (map_wr_in.index == 6'(gm));
      always_ff @(posedge clk_in or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
          out_map_reg[gm] <= prc_pkg::SEL_NULL;
        else if (hit)
          out_map_reg[gm] <= map_wr_in.value;
      end
    end
  endgenerate

  // pin sampling: three stages, a change counts when stages two and three agree
  logic [prc_pkg::REMAP_PINS-1:0] rp_s1_reg;
  logic [prc_pkg::REMAP_PINS-1:0] rp_s2_reg;
  logic [prc_pkg::REMAP_PINS-1:0] rp_s3_reg;
  logic [prc_pkg::REMAP_PINS-1:0] rp_val_reg;
  logic [NW-1:0]                  cd_s1_reg;
  logic [NW-1:0]                  cd_s2_reg;
  logic [NW-1:0]                  cd_s3_reg;
  logic [NW-1:0]                  cd_val_reg;
  logic [NW-1:0]                  cd_last_reg;
  logic [NW-1:0]                  cd_pin_wide;
  assign cd_pin_wide = {{(NW - prc_pkg::CD_PINS){1'b0}}, cd_pin_in};

  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rp_s1_reg  <= '0;
      rp_s2_reg  <= '0;
      rp_s3_reg  <= '0;
      rp_val_reg <= '0;
      cd_s1_reg  <= '0;
      cd_s2_reg  <= '0;
      cd_s3_reg  <= '0;
      cd_val_reg <= '0;
    end
    else
    begin
      rp_s1_reg  <= rp_pin_in;
      rp_s2_reg  <= rp_s1_reg;
      rp_s3_reg  <= rp_s2_reg;
      rp_val_reg <= (rp_s2_reg & rp_s3_reg) | (rp_val_reg & (rp_s2_reg | rp_s3_reg));
      cd_s1_reg  <= cd_pin_wide;
      cd_s2_reg  <= cd_s1_reg;
      cd_s3_reg  <= cd_s2_reg;
      cd_val_reg <= (cd_s2_reg & cd_s3_reg) | (cd_val_reg & (cd_s2_reg | cd_s3_reg));
    end
  end

  // change detect banks; sleep wake-up is assumed to come from the clocked
  // flag since no asynchronous path exists in this one-clock design
  logic [NW-1:0] cn_en_reg;
  logic [NW-1:0] pu_reg;
  logic [NW-1:0] pd_reg;
  logic          cd_flag_reg;
  wire  [NW-1:0] cd_diff = (cd_val_reg ^ cd_last_reg) & cn_en_reg;
  wire           cd_hit  = |cd_diff;

  // one strobe per bank; a bank code past the last bank matches none
  genvar gb;
  generate
    for (gb = 0; gb < prc_pkg::CD_BANKS; gb++)
    begin : g_bank
      localparam int unsigned LO = gb * prc_pkg::BANK_W;
      wire en_hit = cn_en_wr_in.wr && (cn_en_wr_in.bank == 3'(gb));
      wire pu_hit = pu_wr_in.wr && (pu_wr_in.bank == 3'(gb));
      wire pd_hit = pd_wr_in.wr && (pd_wr_in.bank == 3'(gb));
      always_ff @(posedge clk_in or negedge rst_sync_n)
      begin
        if (!rst_sync_n)
        begin
          cn_en_reg[LO +: prc_pkg::BANK_W] <= '0;
          pu_reg[LO +: prc_pkg::BANK_W]    <= '0;
          pd_reg[LO +: prc_pkg::BANK_W]    <= '0;
        end
        else
        begin
          if (en_hit)
            cn_en_reg[LO +: prc_pkg::BANK_W] <= cn_en_wr_in.data;
          if (pu_hit)
            pu_reg[LO +: prc_pkg::BANK_W] <= pu_wr_in.data;
          if (pd_hit)
            pd_reg[LO +: prc_pkg::BANK_W] <= pd_wr_in.data;
        end
      end
    end
  endgenerate

  // recorded level follows every cycle, so a mismatch lasts one cycle
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cd_last_reg <= '0;
    else
      cd_last_reg <= cd_val_reg;
  end

  // set wins over clear so a change in the clearing cycle is not lost
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      cd_flag_reg <= 1'b0;
    else if (cd_hit)
      cd_flag_reg <= 1'b1;
    else if (cd_flag_clr_in)
      cd_flag_reg <= 1'b0;
  end
  assign cd_irq_out   = cd_flag_reg;
  assign pullup_out   = pu_reg[prc_pkg::CD_PINS-1:0]; // left to software
  assign pulldown_out = pd_reg[prc_pkg::CD_PINS-1:0];

  // digital-mode pin view; analog pins read low to remapped inputs
  wire [prc_pkg::REMAP_PINS-1:0] rp_digital = rp_val_reg & ~rp_analog_in;

  // input mapping: per function select, codes beyond 45 give zero
  logic [prc_pkg::IN_FUNCS-1:0] pin_in_reg;
  logic [prc_pkg::IN_FUNCS-1:0] pin_in_next;
  genvar gi;
  generate
    for (gi = 0; gi < prc_pkg::IN_FUNCS; gi++)
    begin : g_in
      assign pin_in_next[gi] = (in_map_reg[gi] < 6'(prc_pkg::REMAP_PINS)) ?
                               rp_digital[in_map_reg[gi]] : 1'b0;
    end
  endgenerate
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pin_in_reg <= '0;
    else
      pin_in_reg <= pin_in_next;
  end
  assign periph_in_out = pin_in_reg;

  // output mapping: only bidir pins exist here, so input-only pins stay
  // undriven by construction; remapped inputs never touch oe
  logic [prc_pkg::BIDIR_PINS-1:0] oe_next;
  logic [prc_pkg::BIDIR_PINS-1:0] dat_next;
  logic [prc_pkg::BIDIR_PINS-1:0] oe_reg;
  logic [prc_pkg::BIDIR_PINS-1:0] dat_reg;
  genvar go;
  generate
    for (go = 0; go < prc_pkg::BIDIR_PINS; go++)
    begin : g_out
      wire [prc_pkg::OUT_SEL_W-1:0] f = out_map_reg[go][prc_pkg::OUT_SEL_W-1:0];
      wire mapped = (out_map_reg[go] != prc_pkg::SEL_NULL) &&
                    (out_map_reg[go] < 6'(prc_pkg::OUT_FUNCS));
      wire rm_oe  = mapped && periph_oe_in[f];
      assign oe_next[go]  = special_oe_in[go] | rm_oe | pmp_oe_in[go] |
                            ~port_dir_in[go];
      assign dat_next[go] = special_oe_in[go] ? special_dat_in[go] :
                            rm_oe ? periph_out_in[f] :
                            pmp_oe_in[go] ? pmp_dat_in[go] : port_lat_in[go];
    end
  endgenerate
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      oe_reg  <= '0;
      dat_reg <= '0;
    end
    else
    begin
      oe_reg  <= oe_next;
      dat_reg <= dat_next;
    end
  end
  assign rp_oe_out  = oe_reg;
  assign rp_pin_out = dat_reg;
endmodule : prc_remap

// ---- hw/prc_pkg.sv ----
package prc_pkg;
  localparam int unsigned CD_PINS     = 81;
  localparam int unsigned CD_BANKS    = 6;
  localparam int unsigned BANK_W      = 16;
  localparam int unsigned REMAP_PINS  = 46;
  localparam int unsigned BIDIR_PINS  = 32;
  localparam int unsigned SEL_W       = 6;
  localparam int unsigned IN_FUNCS    = 36;
  localparam int unsigned OUT_FUNCS   = 32;
  localparam int unsigned IN_SEL_W    = 6;
  localparam int unsigned OUT_SEL_W   = 5;
  localparam logic [SEL_W-1:0] SEL_NULL  = 6'h00;
  localparam logic [SEL_W-1:0] IN_RESET  = 6'h3f;
  localparam logic [7:0] UNLOCK_KEY1     = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2     = 8'haa;

  typedef struct packed {
    logic                    wr;
    logic                    out_sel;
    logic [IN_SEL_W-1:0]     index;
    logic [SEL_W-1:0]        value;
  } prc_map_wr_s;

  typedef struct packed {
    logic                    wr;
    logic [2:0]              bank;
    logic [BANK_W-1:0]       data;
  } prc_bank_wr_s;

  typedef enum logic [2:0] {
    LK_LOCKED = 3'b001,
    LK_KEY1   = 3'b010,
    LK_OPEN   = 3'b100
  } prc_lock_e;
endpackage : prc_pkg

// ---- verification/prc_remap_checker.sv ----
`timescale 1ns/100ps
module prc_remap_checker (
  input wire logic                  clk_in,
  input wire logic                  rst_n_in,
  input wire logic                  key_wr_in,
  input wire logic [7:0]            key_data_in,
  input wire logic                  lock_set_in,
  input wire logic                  locked_out,
  input wire logic                  cd_flag_clr_in,
  input wire logic                  cd_irq_out,
  input wire prc_pkg::prc_bank_wr_s pu_wr_in,
  input wire logic [80:0]           pullup_out,
  input wire logic [31:0]           port_dir_in,
  input wire logic [31:0]           pmp_oe_in,
  input wire logic [31:0]           periph_oe_in,
  input wire logic [31:0]           special_oe_in,
  input wire logic [31:0]           special_dat_in,
  input wire logic [31:0]           rp_pin_out,
  input wire logic [31:0]           rp_oe_out
);
  logic [2:0] rs_reg;
  // skip the two-flop reset release plus one edge so $past sees live values
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) rs_reg <= 3'h0;
    else rs_reg <= {rs_reg[1:0], 1'b1};
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rs_reg[2]);
  sequence s_unlock;
    locked_out && key_wr_in && key_data_in == 8'h55 ##1 key_wr_in && key_data_in == 8'haa;
  endsequence
  a_unlock_opens: assert property (s_unlock |=> !locked_out)
    else $error("unlock keys did not open the lock");
  a_open_needs_key: assert property ($fell(locked_out) |-> $past(key_wr_in) && $past(key_data_in) == 8'haa)
    else $error("lock opened without the second key");
  a_relock_now: assert property (lock_set_in && !locked_out |=> locked_out)
    else $error("lock request did not relock");
  a_special_oe_wins: assert property (1'b1 |=> (rp_oe_out & $past(special_oe_in)) == $past(special_oe_in))
    else $error("special output not enabled");
  a_special_dat_wins: assert property (1'b1 |=> ((rp_pin_out ^ $past(special_dat_in)) & $past(special_oe_in)) == 32'h0)
    else $error("special output data lost");
  a_idle_no_drive: assert property (&port_dir_in && !(|(special_oe_in | pmp_oe_in | periph_oe_in)) |=> rp_oe_out == 32'h0)
    else $error("pin driven with no output source");
  a_irq_sticky: assert property (cd_irq_out && !cd_flag_clr_in |=> cd_irq_out)
    else $error("change flag dropped without clear");
  a_pullup_write: assert property (pu_wr_in.wr && pu_wr_in.bank == 3'h0 |=> pullup_out[15:0] == $past(pu_wr_in.data))
    else $error("pull-up bank write lost");
  a_pullup_hold: assert property (!pu_wr_in.wr |=> $stable(pullup_out))
    else $error("pull-up changed without a write");
endmodule : prc_remap_checker
bind prc_remap prc_remap_checker u_chk (.clk_in, .rst_n_in, .key_wr_in, .key_data_in, .lock_set_in,
  .locked_out, .cd_flag_clr_in, .cd_irq_out, .pu_wr_in, .pullup_out, .port_dir_in, .pmp_oe_in,
  .periph_oe_in, .special_oe_in, .special_dat_in, .rp_pin_out, .rp_oe_out);

// ---- verification/prc_pin_model.sv ----
`timescale 1ns/100ps
module prc_pin_model (
  input  wire logic [80:0] pullup_in,
  input  wire logic [80:0] pulldown_in,
  input  wire logic [80:0] cd_drv_in,
  input  wire logic [80:0] cd_val_in,
  input  wire logic [31:0] rp_oe_in,
  input  wire logic [31:0] rp_dat_in,
  input  wire logic [45:0] rp_ext_in,
  output logic      [80:0] cd_pin_out,
  output logic      [45:0] rp_pin_out
);
  // released pin: pull-up, else pull-down, else the inverse of its last level
  wire [80:0] float_lvl = pullup_in | (~pulldown_in & ~cd_val_in);
  assign cd_pin_out = (cd_drv_in & cd_val_in) | (~cd_drv_in & float_lvl);
  // pins 32 and up have no driver on chip
  assign rp_pin_out = {rp_ext_in[45:32], (rp_oe_in & rp_dat_in) | (~rp_oe_in & rp_ext_in[31:0])};
endmodule : prc_pin_model

// ---- verification/prc_remap_tb.sv ----
`timescale 1ns/100ps
module prc_remap_tb;
  logic clk_in = 1'b0, rst_n_in = 1'b0, lock_set_in = 1'b0, key_wr_in = 1'b0, cd_flag_clr_in = 1'b0;
  logic locked_out, cd_irq_out;
  logic [7:0] key_data_in = 8'h00;
  prc_pkg::prc_map_wr_s map_wr_in = '0;
  prc_pkg::prc_bank_wr_s cn_en_wr_in = '0, pu_wr_in = '0, pd_wr_in = '0;
  logic [80:0] cd_drv = '1, cd_val = '0, cd_pin_in, pullup_out, pulldown_out;
  logic [45:0] rp_ext = '0, rp_analog_in = '0, rp_pin_in;
  logic [31:0] port_dir_in = '1, port_lat_in = '0, pmp_oe_in = '0, pmp_dat_in = '0;
  logic [31:0] special_oe_in = '0, special_dat_in = '0, periph_out_in = '0, periph_oe_in = '0;
  logic [31:0] rp_pin_out, rp_oe_out;
  logic [35:0] periph_in_out;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  prc_remap u_dut (.clk_in, .rst_n_in, .map_wr_in, .lock_set_in, .key_wr_in, .key_data_in,
    .locked_out, .cn_en_wr_in, .pu_wr_in, .pd_wr_in, .cd_pin_in, .cd_flag_clr_in, .cd_irq_out,
    .pullup_out, .pulldown_out, .rp_pin_in, .rp_analog_in, .port_dir_in, .port_lat_in,
    .pmp_oe_in, .pmp_dat_in, .special_oe_in, .special_dat_in, .periph_out_in, .periph_oe_in,
    .periph_in_out, .rp_pin_out, .rp_oe_out);
  prc_pin_model u_pins (.pullup_in(pullup_out), .cd_drv_in(cd_drv), .cd_val_in(cd_val),
    .pulldown_in(pulldown_out),
    .rp_oe_in(rp_oe_out), .rp_dat_in(rp_pin_out), .rp_ext_in(rp_ext), .cd_pin_out(cd_pin_in),
    .rp_pin_out(rp_pin_in));
  initial forever #50 clk_in = ~clk_in;
  task automatic conclude;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick
  // strobes drop for a full cycle so back-to-back calls never collide
  task automatic map(input logic o, input logic [5:0] i, input logic [5:0] v);
    map_wr_in = '{1'b1, o, i, v};
    tick(1);
    map_wr_in.wr = 1'b0;
    tick(1);
  endtask : map
  task automatic bank(input int w, input logic [2:0] b, input logic [15:0] d);
    if (w == 0) cn_en_wr_in = '{1'b1, b, d};
    else if (w == 1) pu_wr_in = '{1'b1, b, d};
    else pd_wr_in = '{1'b1, b, d};
    tick(1);
    cn_en_wr_in.wr = 1'b0;
    pu_wr_in.wr = 1'b0;
    pd_wr_in.wr = 1'b0;
    tick(1);
  endtask : bank
  task automatic unlock;
    key_wr_in = 1'b1;
    key_data_in = 8'h55;
    tick(1);
    key_data_in = 8'haa;
    tick(1);
    key_wr_in = 1'b0;
    tick(1);
  endtask : unlock
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      conclude();
    end
  end
  initial
  begin
    tick(10);
    rst_n_in = 1'b1;
    tick(4);
    chk(locked_out, 1'b1);
    chk(rp_oe_out, 32'h0);
    chk(periph_in_out, 36'h0);
    port_lat_in[6] = 1'b1;
    port_dir_in[6] = 1'b0;
    periph_oe_in[3] = 1'b1;
    periph_out_in[3] = 1'b1;
    pmp_oe_in[5] = 1'b1;
    map(1'b1, 6'd5, 6'd3);
    chk({rp_oe_out[6], rp_pin_out[6]}, 2'b11);
    chk(rp_pin_out[5], 1'b0);
    unlock();
    chk(locked_out, 1'b0);
    map(1'b1, 6'd5, 6'd3);
    chk(rp_pin_out[5], 1'b1);
    special_oe_in[5] = 1'b1;
    tick(2);
    chk(rp_pin_out[5], 1'b0);
    special_oe_in[5] = 1'b0;
    map(1'b1, 6'd5, 6'd0);
    chk(rp_pin_out[5], 1'b0);
    map(1'b0, 6'd1, 6'd7);
    chk(rp_oe_out[7], 1'b0);
    map(1'b0, 6'd2, 6'd40);
    rp_ext[40] = 1'b1;
    tick(8);
    chk(periph_in_out[2], 1'b1);
    rp_analog_in[40] = 1'b1;
    tick(8);
    chk(periph_in_out[2], 1'b0);
    lock_set_in = 1'b1;
    tick(1);
    lock_set_in = 1'b0;
    map(1'b0, 6'd2, 6'd41);
    rp_analog_in[40] = 1'b0;
    tick(8);
    chk({locked_out, periph_in_out[2]}, 2'b11);
    bank(0, 3'h0, 16'h0001);
    cd_val[1] = 1'b1;
    tick(8);
    chk(cd_irq_out, 1'b0);
    cd_val[0] = 1'b1;
    tick(8);
    chk(cd_irq_out, 1'b1);
    cd_flag_clr_in = 1'b1;
    tick(1);
    cd_flag_clr_in = 1'b0;
    tick(2);
    chk(cd_irq_out, 1'b0);
    bank(1, 3'h0, 16'h0004);
    bank(2, 3'h5, 16'h0001);
    chk({pullup_out[2], pulldown_out[80], pullup_out[80]}, 3'b110);
    bank(0, 3'h0, 16'h0005);
    cd_drv[2] = 1'b0;
    tick(8);
    chk(cd_irq_out, 1'b1);
    lock_set_in = 1'b1;
    tick(1);
    lock_set_in = 1'b0;
    key_wr_in = 1'b1;
    key_data_in = 8'h55;
    tick(1);
    unlock();
    chk(locked_out, 1'b0);
    conclude();
  end
endmodule : prc_remap_tb
